// >>> bench/motion_sync_pulse_io_test.sv
/* bench top for msp_sync_io; inputs change on falling edges, peer on the sync pins */
`timescale 1ns/1ps
`default_nettype none
module motion_sync_pulse_io_test;
	logic clk_sys_i = 1'h0, rst_n_i = 1'h0, clk_en_i = 1'h1, in_enable_i = 1'h1, in_invert_i = 1'h0;
	logic in_absolute_i = 1'h1, move_start_i = 1'h0, move_end_i = 1'h0, moving_i = 1'h0, step_tick_i = 1'h0;
	logic enc_tick_i = 1'h0, out_enable_i = 1'h0, out_invert_i = 1'h0, out_fixed_i = 1'h1, out_width_steps_i = 1'h0;
	logic out_on_start_i = 1'h1, out_on_stop_i = 1'h0, out_periodic_i = 1'h0, sync_in_i, sync_out_o, sync_out_oe_o;
	logic [15:0] in_min_us_i = 16'h0002, out_width_i = 16'h0002, out_period_i = 16'h0003;
	logic [31:0] in_speed_i = 32'h0000_0123, dist_to_go_i = 32'h0000_0064, out_accuracy_i = 32'h0000_000a;
	msp_pkg::msp_pos_s in_target_i = '{32'h0000_0010, 16'h0003}, dest_pos_i = '{32'hffff_fff8, 16'hffff};
	msp_pkg::msp_move_s move_cmd_o;
	int fails = 0, comparisons = 0, w;
	logic g;
	msp_sync_io u_dut (.*);
	msp_peer u_peer (.clk_i(clk_sys_i), .line_i(sync_out_o), .idle_i(out_invert_i), .pin_o(sync_in_i), .width_o(w));
	always #12.5 clk_sys_i = !clk_sys_i;
	task automatic check(input logic [47:0] seen, input logic [47:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			fails++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clk_sys_i);
	endtask
	task automatic got_cmd;
		g = 1'h0;
		repeat (300)
		begin
			cyc(1);
			if (move_cmd_o.valid === 1'h1)
				g = 1'h1;
		end
	endtask
	task automatic pulse(input int len, input logic act);
		fork
			u_peer.send(len, act);
			got_cmd;
		join
	endtask
	task automatic kick(ref logic s);
		s = 1'h1;
		cyc(1);
		s = 1'h0;
		cyc(2);
	endtask
	task automatic t_input;
		pulse(20, 1'h1);
		check(g, 1'h0);
		pulse(200, 1'h1);
		check(g, 1'h1);
		check(move_cmd_o.target, in_target_i);
		check(move_cmd_o.absolute, 1'h1);
		check(move_cmd_o.speed, in_speed_i);
		in_absolute_i = 1'h0;
		pulse(200, 1'h1);
		check(move_cmd_o.target, {32'h0000_0008, 16'h0002});
		check(move_cmd_o.absolute, 1'h0);
		in_invert_i = 1'h1;
		u_peer.pin_o = 1'h1;
		got_cmd;
		check(g, 1'h0);
		pulse(200, 1'h0);
		check(g, 1'h1);
		in_invert_i = 1'h0;
		u_peer.pin_o = 1'h0;
		got_cmd;
		check(g, 1'h0);
		in_enable_i = 1'h0;
		pulse(200, 1'h1);
		check(g, 1'h0);
	endtask
	task automatic t_output;
		out_fixed_i = 1'h0;
		cyc(3);
		check(sync_out_o, 1'h0);
		kick(move_start_i);
		check(sync_out_o, 1'h0);
		out_fixed_i = 1'h1;
		cyc(3);
		check(sync_out_o, 1'h1);
		out_enable_i = 1'h1;
		for (int i = 0; i < 2; i++)
		begin
			out_invert_i = i[0];
			cyc(3);
			kick(move_start_i);
			check(sync_out_o, !i[0]);
			cyc(150);
			check(w >= 40 && w <= 82, 1'h1);
		end
		out_invert_i = 1'h0;
		out_on_start_i = 1'h0;
		out_on_stop_i = 1'h1;
		moving_i = 1'h1;
		kick(move_start_i);
		cyc(100);
		check(sync_out_o, 1'h0);
		dist_to_go_i = 32'h0000_0005;
		cyc(3);
		check(sync_out_o, 1'h1);
		moving_i = 1'h0;
		dist_to_go_i = 32'h0000_0064;
		cyc(150);
		kick(move_start_i);
		kick(move_end_i);
		check(sync_out_o, 1'h1);
		cyc(150);
		out_on_stop_i = 1'h0;
		out_periodic_i = 1'h1;
		for (int i = 0; i < 3; i++)
		begin
			kick(enc_tick_i);
			check(sync_out_o, i == 2);
		end
	endtask
	task automatic t_steps;
		cyc(150);
		out_periodic_i = 1'h0;
		out_on_start_i = 1'h1;
		out_width_steps_i = 1'h1;
		kick(move_start_i);
		cyc(100);
		check(sync_out_o, 1'h1);
		kick(step_tick_i);
		check(sync_out_o, 1'h1);
		kick(move_start_i);
		kick(step_tick_i);
		check(sync_out_o, 1'h1);
		kick(enc_tick_i);
		check(sync_out_o, 1'h0);
	endtask
	task automatic close_out;
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial
	begin
		cyc(3);
		rst_n_i = 1'h1;
		cyc(2);
		t_input;
		t_output;
		t_steps;
		close_out;
	end
	// run needs about 3100 cycles; the limit allows more than twelve times that
	initial
	begin
		#1ms;
		fails++;
		close_out;
	end
endmodule // motion_sync_pulse_io_test
`default_nettype wire

// >>> bench/msp_peer.sv
/* far-side equipment: sends sync pulses, times returned pulse; bench calls send at falling edges */
`timescale 1ns/1ps
`default_nettype none
module msp_peer (
	// clock and line
	input wire logic  clk_i, line_i, idle_i,
	// pin and measured width
	output logic      pin_o,
	output int        width_o
);
	int n = 0;
	initial pin_o = 1'h0;
	// each pulse asks an instant start
	task automatic send(input int cyc, input logic act);
		pin_o = act;
		repeat (cyc) @(negedge clk_i);
		pin_o = !act;
	endtask
	always @(posedge clk_i)
	begin
		if (line_i !== idle_i)
			n <= n + 1;
		else if (n != 0)
		begin
			width_o <= n;
			n <= 0;
		end
	end
endmodule // msp_peer
`default_nettype wire

// >>> bench/msp_sync_io_assertions.sv
/* checker bound to msp_sync_io; assumes clk_en_i held high */
`timescale 1ns/1ps
`default_nettype none
module msp_sync_io_chk #(parameter int unsigned CNT_W = 16) (
	// watched ports
	input wire logic                 clk_sys_i, rst_n_i, clk_en_i, in_enable_i, in_absolute_i,
	input wire logic                 move_start_i, out_enable_i, out_invert_i, out_fixed_i, out_on_start_i,
	input wire logic [CNT_W-1:0]     out_width_i,
	input wire logic [31:0]          in_speed_i,
	input wire msp_pkg::msp_pos_s    in_target_i, dest_pos_i,
	input wire msp_pkg::msp_move_s   move_cmd_o,
	input wire logic                 sync_out_o, sync_out_oe_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);
	a_oe_high: assert property (sync_out_oe_o) else $error("oe low");
	a_out_fixed: assert property (!out_enable_i && clk_en_i |=> sync_out_o == $past(out_fixed_i))
		else $error("fixed level");
	a_start_pulse: assert property (move_start_i && out_on_start_i && out_enable_i && out_width_i != 0
		|-> ##2 sync_out_o == !out_invert_i) else $error("start pulse");
	a_cmd_once: assert property (move_cmd_o.valid |=> !move_cmd_o.valid) else $error("cmd twice");
	a_cmd_off: assert property (!$past(in_enable_i) |-> !move_cmd_o.valid) else $error("cmd off");
	a_cmd_speed: assert property (move_cmd_o.valid |-> move_cmd_o.speed == in_speed_i) else $error("speed");
	a_cmd_abs: assert property (move_cmd_o.valid && in_absolute_i |-> move_cmd_o.target == in_target_i)
		else $error("abs target");
	a_cmd_rel: assert property (move_cmd_o.valid && !in_absolute_i |->
		move_cmd_o.target.steps == dest_pos_i.steps + in_target_i.steps &&
		move_cmd_o.target.usteps == dest_pos_i.usteps + in_target_i.usteps) else $error("rel target");
endmodule // msp_sync_io_chk
bind msp_sync_io msp_sync_io_chk #(.CNT_W(CNT_W)) u_chk (.*);
`default_nettype wire

// >>> core/msp_pkg.sv
/*
 * Constants and carrier types for the sync pulse input/output block.
 * Assumes a 40 MHz system clock; settings arrive as static-ish configuration ports.
 */
// Overview of operation
// R1: Input pulses shorter than the configured minimum microseconds are ignored.
// R2: Input pulses act only while sync input is enabled.
// R3: With input invert set, the falling edge of a qualified pulse triggers.
// R4: With input invert clear, the rising edge of a qualified pulse triggers.
// R5: Absolute mode commands a move to the configured target position.
// R6: Relative mode commands a shift from the current destination position.
// R7: Sync-triggered moves use the configured sync speed.
// R8: Configuring party should clear jerk-free and power-off-at-stop for instant start.
// R9: Output line also serves as a general-purpose output.
// R10: Output disabled holds the fixed-state level, ignoring pulse settings.
// R11: Fixed-state selects static output level 0 or 1.
// R12: Output invert makes logic zero the active pulse level.
// R13: Pulse width counts microseconds, or steps/encoder pulses, per configuration.
// R14: On-start emits one pulse when a movement begins.
// R15: On-stop emits one pulse at the end of a movement.
// R16: Periodic mode emits a pulse every n encoder pulses.
// R17: On-stop pulse fires once remaining distance is within the accuracy window.
// R18: Retriggering during an active pulse restarts the width from the latest trigger.
`default_nettype none
package msp_pkg;
	localparam int unsigned CLK_HZ        = 40000000;
	localparam int unsigned US_PER_S      = 1000000;
	// one microsecond in clock cycles
	localparam int unsigned CYC_PER_US    = CLK_HZ / US_PER_S;
	localparam int unsigned US_CNT_W      = 6;
	localparam int unsigned POS_W         = 32;
	localparam int unsigned USTEP_W       = 16;
	localparam int unsigned SPD_W         = 32;
	localparam int unsigned CNT_W         = 16;
	localparam logic        OUT_RST_LEVEL = 1'h0;

	typedef struct packed {
		logic [POS_W-1:0]   steps;
		logic [USTEP_W-1:0] usteps;
	} msp_pos_s;

	typedef struct packed {
		logic               valid;
		logic               absolute;
		msp_pos_s           target;
		logic [SPD_W-1:0]   speed;
	} msp_move_s;
endpackage
`default_nettype wire

// >>> core/msp_sync_io.sv
/*
 * Sync input qualifier/move commander and sync output pulse generator.
 * Assumes sync_in_i is asynchronous; motion status/encoder strobes are on clk_sys_i.
 */
`timescale 1ns/1ps
`default_nettype none
module msp_sync_io #(
	parameter int unsigned CNT_W = msp_pkg::CNT_W
) (
	// clock, reset, enable
	input  wire logic                          clk_sys_i,
	input  wire logic                          rst_n_i,
	input  wire logic                          clk_en_i,
	// sync input pin and its settings
	input  wire logic                          sync_in_i,
	input  wire logic                          in_enable_i,
	input  wire logic                          in_invert_i,
	input  wire logic [CNT_W-1:0]              in_min_us_i,
	input  wire logic                          in_absolute_i,
	input  wire msp_pkg::msp_pos_s             in_target_i,
	input  wire logic [msp_pkg::SPD_W-1:0]     in_speed_i,
	input  wire msp_pkg::msp_pos_s             dest_pos_i,
	// motion status from the axis
	input  wire logic                          move_start_i,
	input  wire logic                          move_end_i,
	input  wire logic                          moving_i,
	input  wire logic [msp_pkg::POS_W-1:0]     dist_to_go_i,
	input  wire logic                          step_tick_i,
	input  wire logic                          enc_tick_i,
	// sync output settings
	input  wire logic                          out_enable_i,
	input  wire logic                          out_invert_i,
	input  wire logic                          out_fixed_i,
	input  wire logic [CNT_W-1:0]              out_width_i,
	input  wire logic                          out_width_steps_i,
	input  wire logic                          out_on_start_i,
	input  wire logic                          out_on_stop_i,
	input  wire logic                          out_periodic_i,
	input  wire logic [CNT_W-1:0]              out_period_i,
	input  wire logic [msp_pkg::POS_W-1:0]     out_accuracy_i,
	// outputs
	output msp_pkg::msp_move_s                 move_cmd_o,
	output logic                               sync_out_o,
	output logic                               sync_out_oe_o
);

	logic             sync_meta_q;
	logic             sync_s_q;
	logic             raw_q;
	logic             stable_q;
	logic [msp_pkg::US_CNT_W-1:0] us_div_q;
	logic             us_tick;
	logic [CNT_W-1:0] hold_us_q;
	logic             stable_d;
	logic             trig;
	msp_pkg::msp_move_s move_q;
	logic             near_q;
	logic [CNT_W-1:0] per_cnt_q;
	logic [CNT_W-1:0] width_q;
	logic             act_q;
	logic             out_q;
	logic             fire;
	logic             per_fire;
	logic             near_now;
	logic             oe_q;

	// two-stage synchroniser on the pin
	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			sync_meta_q <= 1'h0;
			sync_s_q    <= 1'h0;
		end
		else if (clk_en_i)
		begin
			sync_meta_q <= sync_in_i;
			sync_s_q    <= sync_meta_q;
		end
	end

	// free-running microsecond tick
	assign us_tick = (us_div_q == msp_pkg::US_CNT_W'(msp_pkg::CYC_PER_US - 1));

	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			us_div_q <= '0;
		else if (clk_en_i)
			us_div_q <= us_tick ? '0 : us_div_q + 1'h1;
	end

	// R1 debounce: level accepted only after minimum hold
	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			raw_q     <= 1'h0;
			hold_us_q <= '0;
			stable_q  <= 1'h0;
		end
		else if (clk_en_i)
		begin
			raw_q <= sync_s_q;
			if (sync_s_q != raw_q)
				hold_us_q <= '0;
			else if (us_tick && hold_us_q != '1)
				hold_us_q <= hold_us_q + 1'h1;
			stable_q <= stable_d;
		end
	end

	// a level shorter than the minimum never reaches stable_q
	assign stable_d = (sync_s_q == raw_q && hold_us_q >= in_min_us_i) ? raw_q : stable_q;

	// R3 falling edge when inverted / R4 rising edge otherwise
	assign trig = clk_en_i && (stable_d != stable_q) && (stable_d == !in_invert_i);

	// move command to the axis; ramp settings stay outside this block
	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			move_q <= '0;
		else if (clk_en_i)
		begin
			move_q.valid <= 1'h0;
			// R2 gate on enable
			if (trig && in_enable_i)
			begin
				move_q.valid    <= 1'h1;
				move_q.absolute <= in_absolute_i;
				// R7 sync speed
				move_q.speed    <= in_speed_i;
				// R5 absolute target
				if (in_absolute_i)
					move_q.target <= in_target_i;
				// R6 shift from destination
				else
					move_q.target <= {dest_pos_i.steps + in_target_i.steps,
					                  dest_pos_i.usteps + in_target_i.usteps};
			end
		end
	end

	assign move_cmd_o = move_q;

	// R17 approach window, one pulse per movement
	assign near_now = moving_i && (dist_to_go_i <= out_accuracy_i);

	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			near_q <= 1'h0;
		else if (clk_en_i)
			near_q <= move_start_i ? 1'h0 : (near_q | near_now | move_end_i);
	end

	// R16 encoder pulse period counter
	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			per_cnt_q <= '0;
		else if (clk_en_i)
		begin
			// restart the count while periodic mode is off, so n counts from enabling
			if (!out_periodic_i)
				per_cnt_q <= '0;
			else if (enc_tick_i)
				per_cnt_q <= per_fire ? '0 : per_cnt_q + 1'h1;
		end
	end

	assign per_fire = out_periodic_i && enc_tick_i && out_period_i != '0
	                  && (per_cnt_q + 1'h1 >= out_period_i);

	// R14 start / R15 end / R16 periodic
	assign fire = (out_on_start_i && move_start_i)
	              || (out_on_stop_i && !near_q && (near_now || move_end_i))
	              || per_fire;

	// R13 width in us or steps; R18 restart on retrigger
	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			width_q <= '0;
			act_q   <= 1'h0;
		end
		else if (clk_en_i)
		begin
			if (!out_enable_i)
				act_q <= 1'h0;
			else if (fire && out_width_i != '0)
			begin
				width_q <= out_width_i;
				act_q   <= 1'h1;
			end
			else if (act_q && (out_width_steps_i ? (step_tick_i || enc_tick_i) : us_tick))
			begin
				width_q <= width_q - 1'h1;
				if (width_q == CNT_W'(1))
					act_q <= 1'h0;
			end
		end
	end

	// R9 R10 R11 fixed level when disabled; R12 inverted active level
	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			out_q <= msp_pkg::OUT_RST_LEVEL;
		else if (clk_en_i)
			out_q <= !out_enable_i ? out_fixed_i : (act_q ^ out_invert_i);
	end

	// R9 line always driven; registered so every output leaves a flop
	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			oe_q <= 1'h1;
		else if (clk_en_i)
			oe_q <= 1'h1;
	end

	assign sync_out_o    = out_q;
	assign sync_out_oe_o = oe_q;

endmodule // msp_sync_io
`default_nettype wire
